// *** cbe_pkg.sv ***
// Shared types and constants for the card block, erase and protection controller
package cbe_pkg;
  // ==========================================================================
  // Memory geometry
  localparam int              SEC_W       = 6;
  localparam int              OFS_W       = 9;
  localparam int              ADDR_W      = SEC_W + OFS_W;
  localparam int              NSEC        = 64;
  localparam logic [31:0]     MEM_BYTES   = 32'h0000_8000;
  localparam logic [8:0]      SEC_LAST    = 9'h1FF;
  localparam logic [14:0]     ADDR_LAST   = 15'h7FFF;
  localparam logic [14:0]     SEC_STEP    = 15'h0200;
  localparam logic [9:0]      BLK_MAX     = 10'h200;
  localparam logic [9:0]      BLK_RESET   = 10'h200;
  localparam int              GRP16_SHIFT = 4;
  localparam int              GRP32_SHIFT = 5;
  localparam logic [7:0]      ERASED_BYTE = 8'hFF;
  localparam int              ARG_GROUP   = 31;
  // ==========================================================================
  // Host-controlled config bits (low 16 bits of the config register)
  localparam int              CFG_FMT_GRP = 15;
  localparam int              CFG_COPY    = 14;
  localparam int              CFG_PERM_WP = 13;
  localparam int              CFG_TMP_WP  = 12;
  localparam logic [15:0]     CFG_RESET   = 16'h0001;
  localparam logic [15:0]     CFG_STICKY  = 16'h6000;
  // Maker bytes: value is arbitrary
  localparam logic [111:0]    MAKER_DATA  = 112'h0123_4567_89AB_CDEF_0123_4567_89AB;
  // ==========================================================================
  // Status bits
  localparam int              ST_ADDR     = 31;
  localparam int              ST_ALIGN    = 30;
  localparam int              ST_BLKLEN   = 29;
  localparam int              ST_ER_SEQ   = 28;
  localparam int              ST_ER_PARAM = 27;
  localparam int              ST_WP       = 26;
  localparam int              ST_ILLEGAL  = 22;
  localparam int              ST_ECC_FAIL = 21;
  localparam int              ST_CFG_OVR  = 16;
  localparam int              ST_READY    = 8;
  // ==========================================================================
  typedef enum logic [4:0] {
    CMD_READ_SINGLE, CMD_READ_MULTI, CMD_WRITE_SINGLE, CMD_WRITE_MULTI, CMD_STOP,
    CMD_SET_BLKLEN, CMD_TAG_START, CMD_TAG_END, CMD_DESELECT_ERASE, CMD_ERASE,
    CMD_PROGRAM_CONFIG, CMD_READ_CONFIG, CMD_SEND_STATUS, CMD_OP_COND, CMD_IDENTIFY,
    CMD_DATA_IN, CMD_DATA_OUT
  } cbe_cmd_t;
  typedef struct packed {
    cbe_cmd_t    cmd;
    logic [31:0] arg;
  } cbe_req_t;
  typedef struct packed {
    logic [31:0] status;
    logic [7:0]  data;
  } cbe_rsp_t;
endpackage : cbe_pkg

// *** cbe_card_ctrl.sv ***
// Card-side block transfer, tagged erase, ECC and write protection controller
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - multi-block data at consecutive addresses from command
// - stop command ends a multi-block transfer
// - ECC made on write, checked on read
// - correctable defects fixed before data leaves
// - sector is smallest erase unit, many per erase
// - start then end address tags whole range
// - deselect command removes sector or group
// - groups of 16 or 32, tag by either
// - permanent and temporary write protect via config
// - permanent protect cannot be cleared
// - copy bit sticks, clear attempt rejected
// - only two low config bytes host-changeable
// - read config and program config commands
// - serial mode refuses voltage negotiation
// - serial mode has no identification
// - serial mode status is 16 bits
// - serial mode addresses are byte addresses
// - serial mode supports multi-block transfers
module cbe_card_ctrl import cbe_pkg::*; (
  input  wire logic   ref_clk,
  input  wire logic   rst_b,
  input  wire logic   spi_mode,
  input  wire logic   grp32,
  input  wire logic   link_clk,
  input  wire logic   req_valid,
  input  wire cbe_req_t req,
  output var  logic   req_busy,
  output var  logic   rsp_valid,
  output var  cbe_rsp_t rsp,
  output var  logic [15:0] cfg_low
);
  typedef enum {S_IDLE, S_CHECK, S_RD, S_WR, S_CFG, S_ERASE} cbe_state_t;
  typedef enum {ER_NONE, ER_START, ER_END} cbe_erase_t;

  function automatic logic [12:0] ecc_acc(input logic [12:0] acc, input logic [7:0] d,
                                          input logic [8:0] ofs);
    logic [12:0] r;
    r = acc;
    for (int b = 0; b < 8; b++) begin
      if (d[b]) r = r ^ {1'b1, ofs, 3'(b)};
    end
    return r;
  endfunction : ecc_acc

  function automatic logic [5:0] grp_of(input logic [5:0] s, input logic g32);
    return g32 ? (s >> GRP32_SHIFT) : (s >> GRP16_SHIFT);
  endfunction : grp_of

  // ==========================================================================
  // Link domain: request capture and answer return
  logic     lrst_s1, lrst_s2, ack_s1, ack_s2;
  logic     busy_reg, busy_next, req_tgl_reg, req_tgl_next, ack_seen_reg, ack_seen_next;
  logic     rsp_valid_reg, rsp_valid_next;
  cbe_req_t hold_reg, hold_next;
  cbe_rsp_t rsp_reg, rsp_next;
  logic     ack_tgl_reg, ack_tgl_next;
  cbe_rsp_t rsp_hold_reg, rsp_hold_next;

  always_comb begin
    busy_next      = busy_reg;
    req_tgl_next   = req_tgl_reg;
    hold_next      = hold_reg;
    ack_seen_next  = ack_seen_reg;
    rsp_next       = rsp_reg;
    rsp_valid_next = 1'b0;
    // Busy blocks new requests so the held word stays stable for the core
    if (req_valid && !busy_reg) begin
      hold_next    = req;
      req_tgl_next = ~req_tgl_reg;
      busy_next    = 1'b1;
    end
    if (ack_s2 != ack_seen_reg) begin
      ack_seen_next  = ack_s2;
      rsp_next       = rsp_hold_reg;
      rsp_valid_next = 1'b1;
      busy_next      = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    lrst_s1 <= rst_b;
    lrst_s2 <= lrst_s1;
    ack_s1  <= ack_tgl_reg;
    ack_s2  <= ack_s1;
    if (!lrst_s2) begin
      busy_reg      <= 1'b0;
      req_tgl_reg   <= 1'b0;
      hold_reg      <= '0;
      ack_seen_reg  <= 1'b0;
      rsp_reg       <= '0;
      rsp_valid_reg <= 1'b0;
    end else begin
      busy_reg      <= busy_next;
      req_tgl_reg   <= req_tgl_next;
      hold_reg      <= hold_next;
      ack_seen_reg  <= ack_seen_next;
      rsp_reg       <= rsp_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  assign req_busy  = busy_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp       = rsp_reg;

  // ==========================================================================
  // Core domain: memory, ECC, erase tagging, config register
  logic [7:0]  sec_mem [0:NSEC*512-1];
  logic [11:0] ecc_pos_mem [0:NSEC-1];
  logic        ecc_par_mem [0:NSEC-1];
  logic        req_s1, req_s2, seen_reg, seen_next;
  cbe_state_t  st_reg, st_next;
  cbe_erase_t  er_reg, er_next;
  logic [14:0] addr_reg, addr_next, cnt_reg, cnt_next;
  logic        multi_reg, multi_next, er_grp_reg, er_grp_next, fix_en_reg, fix_en_next;
  logic [9:0]  blk_reg, blk_next;
  logic [12:0] acc_reg, acc_next, syn, ecc_wd;
  logic [11:0] fix_pos_reg, fix_pos_next;
  logic [31:0] err_reg, err_next, new_err, full_st;
  logic [5:0]  er_start_reg, er_start_next, sec, arg_sec, esec;
  logic [NSEC-1:0] tag_reg, tag_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [127:0] cfg_full;
  logic        proc, do_ack, arg_oor, mem_we, ecc_we;
  logic [14:0] mem_wa;
  logic [7:0]  mem_wd, rdat, fix_mask;
  logic [5:0]  ecc_wa;
  cbe_req_t    rq;

  always_comb begin
    seen_next = seen_reg;       st_next = st_reg;         er_next = er_reg;
    addr_next = addr_reg;       cnt_next = cnt_reg;       multi_next = multi_reg;
    er_grp_next = er_grp_reg;   fix_en_next = fix_en_reg; blk_next = blk_reg;
    acc_next = acc_reg;         fix_pos_next = fix_pos_reg;
    er_start_next = er_start_reg; tag_next = tag_reg;     cfg_next = cfg_reg;
    ack_tgl_next = ack_tgl_reg; rsp_hold_next = rsp_hold_reg;
    new_err = 32'h0000_0000;    do_ack = 1'b0;            rdat = 8'h00;
    mem_we = 1'b0;              mem_wa = addr_reg;        mem_wd = 8'h00;
    ecc_we = 1'b0;              syn = 13'h0000;           ecc_wd = 13'h0000;
    rq       = hold_reg;        // Stable while the link side is busy
    sec      = addr_reg[ADDR_W-1:OFS_W];
    esec     = cnt_reg[ADDR_W-1:OFS_W];
    ecc_wa   = sec;
    arg_sec  = rq.arg[ADDR_W-1:OFS_W];
    arg_oor  = rq.arg[30:0] >= MEM_BYTES[30:0];
    cfg_full = {MAKER_DATA, cfg_reg};
    fix_mask = (fix_en_reg && fix_pos_reg[11:3] == addr_reg[OFS_W-1:0])
               ? (8'h01 << fix_pos_reg[2:0]) : 8'h00;
    proc = (req_s2 != seen_reg) && (st_reg inside {S_IDLE, S_RD, S_WR, S_CFG});
    case (st_reg)
      S_CHECK: begin // Whole-sector pass before the first byte leaves
        acc_next = ecc_acc(acc_reg, sec_mem[{sec, cnt_reg[OFS_W-1:0]}], cnt_reg[OFS_W-1:0]);
        cnt_next = cnt_reg + 15'h0001;
        if (cnt_reg[OFS_W-1:0] == SEC_LAST) begin
          syn          = acc_next ^ {ecc_par_mem[sec], ecc_pos_mem[sec]};
          fix_en_next  = syn[12];
          fix_pos_next = syn[11:0];
          new_err[ST_ECC_FAIL] = !syn[12] && (syn[11:0] != 12'h000);
          cnt_next     = 15'h0000;
          st_next      = S_RD;
        end
      end
      S_ERASE: begin // Walk all sectors, wipe the tagged ones
        mem_wa   = cnt_reg;
        mem_wd   = ERASED_BYTE;
        mem_we   = tag_reg[esec];
        ecc_wa   = esec;
        acc_next = ecc_acc(acc_reg, ERASED_BYTE, cnt_reg[OFS_W-1:0]);
        cnt_next = cnt_reg + 15'h0001;
        if (cnt_reg[OFS_W-1:0] == SEC_LAST) begin
          ecc_we   = tag_reg[esec];
          ecc_wd   = acc_next;
          acc_next = 13'h0000;
        end
        if (cnt_reg == ADDR_LAST) begin
          st_next  = S_IDLE;
          er_next  = ER_NONE;
          tag_next = '0;
        end
      end
      default: ;
    endcase
    if (proc) begin
      seen_next = req_s2;
      do_ack    = 1'b1;
      // Any foreign command except send status cancels a half-done erase selection
      if (er_reg != ER_NONE && !(rq.cmd inside {CMD_TAG_END, CMD_DESELECT_ERASE, CMD_ERASE,
                                                  CMD_SEND_STATUS, CMD_TAG_START})) begin
        new_err[ST_ER_SEQ] = 1'b1;
        er_next  = ER_NONE;
        tag_next = '0;
      end
      case (rq.cmd)
        // Byte addresses in both modes
        CMD_READ_SINGLE, CMD_READ_MULTI: begin
          if (arg_oor) new_err[ST_ADDR] = 1'b1;
          else if ({1'b0, rq.arg[OFS_W-1:0]} + blk_reg > BLK_MAX) new_err[ST_BLKLEN] = 1'b1;
          else begin
            addr_next  = rq.arg[ADDR_W-1:0];
            multi_next = (rq.cmd == CMD_READ_MULTI);
            cnt_next = 15'h0000; acc_next = 13'h0000; fix_en_next = 1'b0;
            st_next  = S_CHECK;
          end
        end
        CMD_WRITE_SINGLE, CMD_WRITE_MULTI: begin
          if (arg_oor) new_err[ST_ADDR] = 1'b1;
          else if (rq.arg[OFS_W-1:0] != 9'h000) new_err[ST_ALIGN] = 1'b1;
          else if (cfg_reg[CFG_PERM_WP] || cfg_reg[CFG_TMP_WP]) new_err[ST_WP] = 1'b1;
          else begin
            addr_next  = rq.arg[ADDR_W-1:0];
            multi_next = (rq.cmd == CMD_WRITE_MULTI);
            acc_next   = 13'h0000;
            st_next    = S_WR;
          end
        end
        CMD_DATA_IN: begin
          if (st_reg != S_WR) new_err[ST_ILLEGAL] = 1'b1;
          else begin
            mem_we    = 1'b1;
            mem_wd    = rq.arg[7:0];
            acc_next  = ecc_acc(acc_reg, rq.arg[7:0], addr_reg[OFS_W-1:0]);
            addr_next = addr_reg + 15'h0001;
            if (addr_reg[OFS_W-1:0] == SEC_LAST) begin
              ecc_we   = 1'b1;
              ecc_wd   = acc_next; // Code of the full sector, before the restart
              acc_next = 13'h0000;
              if (!multi_reg || addr_reg == ADDR_LAST) st_next = S_IDLE;
            end
          end
        end
        CMD_DATA_OUT: begin
          if (st_reg == S_RD) begin
            rdat      = sec_mem[addr_reg] ^ fix_mask;
            addr_next = addr_reg + 15'h0001;
            cnt_next  = cnt_reg + 15'h0001;
            if (cnt_reg[9:0] == blk_reg - 10'h001) begin
              st_next  = (multi_reg && addr_reg != ADDR_LAST) ? S_CHECK : S_IDLE;
              cnt_next = 15'h0000; acc_next = 13'h0000; fix_en_next = 1'b0;
            end
          end else if (st_reg == S_CFG) begin // Maker bytes first, then host bytes
            rdat     = cfg_full[{~cnt_reg[3:0], 3'b000} +: 8];
            cnt_next = cnt_reg + 15'h0001;
            if (cnt_reg[3:0] == 4'hF) st_next = S_IDLE;
          end else new_err[ST_ILLEGAL] = 1'b1;
        end
        CMD_STOP: st_next = S_IDLE;
        CMD_SET_BLKLEN: begin
          if (rq.arg == 32'h0000_0000 || rq.arg > {22'h000000, BLK_MAX}) new_err[ST_BLKLEN] = 1'b1;
          else blk_next = rq.arg[9:0];
        end
        CMD_TAG_START: begin
          if (arg_oor) new_err[ST_ADDR] = 1'b1;
          else begin
            er_next = ER_START; er_grp_next = rq.arg[ARG_GROUP];
            er_start_next = arg_sec; tag_next = '0;
          end
        end
        CMD_TAG_END: begin
          if (er_reg != ER_START) begin new_err[ST_ER_SEQ] = 1'b1; er_next = ER_NONE; end
          else if (arg_oor || rq.arg[ARG_GROUP] != er_grp_reg || arg_sec < er_start_reg ||
                   (!er_grp_reg && grp_of(arg_sec, grp32) != grp_of(er_start_reg, grp32)))
          begin // Mixed units, reversed range or sectors across groups
            new_err[ST_ER_PARAM] = 1'b1;
            er_next = ER_NONE;
          end else begin
            er_next = ER_END;
            for (int i = 0; i < NSEC; i++) begin
              tag_next[i] = er_grp_reg
                ? (grp_of(6'(i), grp32) >= grp_of(er_start_reg, grp32) &&
                   grp_of(6'(i), grp32) <= grp_of(arg_sec, grp32))
                : (6'(i) >= er_start_reg && 6'(i) <= arg_sec);
            end
          end
        end
        CMD_DESELECT_ERASE: begin
          if (er_reg != ER_END) new_err[ST_ER_SEQ] = 1'b1;
          else if (rq.arg[ARG_GROUP] != er_grp_reg) new_err[ST_ER_PARAM] = 1'b1;
          else begin
            for (int i = 0; i < NSEC; i++) begin
              if (er_grp_reg ? (grp_of(6'(i), grp32) == grp_of(arg_sec, grp32))
                             : (6'(i) == arg_sec)) tag_next[i] = 1'b0;
            end
          end
        end
        CMD_ERASE: begin
          if (er_reg != ER_END) begin new_err[ST_ER_SEQ] = 1'b1; er_next = ER_NONE; end
          else if (cfg_reg[CFG_PERM_WP] || cfg_reg[CFG_TMP_WP]) new_err[ST_WP] = 1'b1;
          else begin
            st_next = S_ERASE; cnt_next = 15'h0000; acc_next = 13'h0000;
          end
        end
        CMD_PROGRAM_CONFIG: begin // Only the low 16 bits are reachable
          if (cfg_reg[CFG_COPY] && !rq.arg[CFG_COPY]) new_err[ST_CFG_OVR] = 1'b1;
          else cfg_next = rq.arg[15:0] | (cfg_reg & CFG_STICKY);
        end
        CMD_READ_CONFIG: begin st_next = S_CFG; cnt_next = 15'h0000; end
        CMD_SEND_STATUS: ;
        CMD_OP_COND:  new_err[ST_ILLEGAL] = spi_mode;
        CMD_IDENTIFY: new_err[ST_ILLEGAL] = spi_mode;
        default:      new_err[ST_ILLEGAL] = 1'b1;
      endcase
    end
    full_st = err_reg | new_err;
    full_st[ST_READY] = (st_next inside {S_RD, S_WR, S_CFG});
    err_next = err_reg | new_err;
    if (do_ack) begin
      ack_tgl_next = ~ack_tgl_reg;
      rsp_hold_next.data   = rdat;
      rsp_hold_next.status = spi_mode ? {16'h0000, full_st[31:26], full_st[ST_ECC_FAIL],
        full_st[ST_CFG_OVR], 5'h00, full_st[ST_ILLEGAL], 1'b0, full_st[ST_READY]} : full_st;
      err_next = 32'h0000_0000; // Reported once, then cleared
    end
  end

  always_ff @(posedge ref_clk) begin
    req_s1 <= req_tgl_reg;
    req_s2 <= req_s1;
    if (mem_we) sec_mem[mem_wa] <= mem_wd;
    if (ecc_we) begin
      ecc_pos_mem[ecc_wa] <= ecc_wd[11:0];
      ecc_par_mem[ecc_wa] <= ecc_wd[12];
    end
    if (!rst_b) begin
      seen_reg <= 1'b0;  st_reg <= S_IDLE;  er_reg <= ER_NONE;  addr_reg <= '0;
      cnt_reg <= '0;     multi_reg <= 1'b0; er_grp_reg <= 1'b0; fix_en_reg <= 1'b0;
      blk_reg <= BLK_RESET; acc_reg <= '0;  fix_pos_reg <= '0;  err_reg <= '0;
      er_start_reg <= '0; tag_reg <= '0;    cfg_reg <= CFG_RESET;
      ack_tgl_reg <= 1'b0; rsp_hold_reg <= '0;
    end else begin
      seen_reg <= seen_next; st_reg <= st_next; er_reg <= er_next; addr_reg <= addr_next;
      cnt_reg <= cnt_next;   multi_reg <= multi_next; er_grp_reg <= er_grp_next;
      fix_en_reg <= fix_en_next; blk_reg <= blk_next; acc_reg <= acc_next;
      fix_pos_reg <= fix_pos_next; err_reg <= err_next; er_start_reg <= er_start_next;
      tag_reg <= tag_next;   cfg_reg <= cfg_next;
      ack_tgl_reg <= ack_tgl_next; rsp_hold_reg <= rsp_hold_next;
    end
  end

  assign cfg_low = cfg_reg;

  // ==========================================================================
  // Assertions
  sequence read_taken;
    proc && (rq.cmd inside {CMD_READ_SINGLE, CMD_READ_MULTI}) && !arg_oor &&
    ({1'b0, rq.arg[OFS_W-1:0]} + blk_reg <= BLK_MAX);
  endsequence
  sequence check_done;
    ##[1:513] (st_reg == S_RD);
  endsequence
  read_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    read_taken |-> check_done) else $error("sector check did not finish in time");
  perm_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg_reg[CFG_PERM_WP] |=> cfg_reg[CFG_PERM_WP]) else $error("permanent protect cleared");
  copy_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg_reg[CFG_COPY] |=> cfg_reg[CFG_COPY]) else $error("copy bit cleared");
  stop_end_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    proc && rq.cmd == CMD_STOP |=> st_reg == S_IDLE) else $error("stop did not end transfer");
  erase_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    proc && rq.cmd == CMD_ERASE && er_reg != ER_END |=> st_reg != S_ERASE &&
    (rsp_hold_reg.status[ST_ER_SEQ] || rsp_hold_reg.status[ST_ER_SEQ-16]))
    else $error("erase out of order was started");
  deselect_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    proc && rq.cmd == CMD_DESELECT_ERASE && er_reg == ER_END && !er_grp_reg &&
    !rq.arg[ARG_GROUP] |=> !tag_reg[$past(arg_sec)]) else $error("deselected sector still tagged");
  wr_next_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    proc && rq.cmd == CMD_DATA_IN && st_reg == S_WR |=> addr_reg == $past(addr_reg) + 15'h0001)
    else $error("write address not consecutive");
  spi_status_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_ack && spi_mode |=> rsp_hold_reg.status[31:16] == 16'h0000)
    else $error("serial status wider than 16 bits");
  spi_opcond_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    proc && spi_mode && rq.cmd == CMD_OP_COND |=> rsp_hold_reg.status[2])
    else $error("negotiation accepted in serial mode");
  link_busy_a: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    req_valid && !busy_reg |=> busy_reg[*2]) else $error("request not held busy");
endmodule : cbe_card_ctrl
`default_nettype wire

// *** cbe_host_model.sv ***
// Host-side model: offers one request at a time on the link
`timescale 1ns/1ps
`default_nettype none
module cbe_host_model import cbe_pkg::*; (
  input  wire logic     link_clk,
  input  wire logic     req_busy,
  input  wire logic     rsp_valid,
  input  wire cbe_rsp_t rsp,
  output var  logic     req_valid,
  output var  cbe_req_t req
);
  // ==========================================================================
  // Request and answer
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // One request outstanding, next only after the answer
  task automatic xfer(input cbe_cmd_t c, input logic [31:0] a, output cbe_rsp_t r);
    int n;
    n = 0;
    @(negedge link_clk);
    while (req_busy !== 1'b0 && n < 4000) begin
      @(negedge link_clk);
      n++;
    end
    req_valid = 1'b1;
    req       = '{cmd: c, arg: a};
    @(negedge link_clk);
    req_valid = 1'b0;
    // Released lines must not keep showing the last value
    req       = cbe_req_t'(~req);
    n         = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge link_clk);
      n++;
    end
    // A missing answer must not pass as an old one
    r = (rsp_valid === 1'b1) ? rsp : cbe_rsp_t'('x);
  endtask : xfer
endmodule : cbe_host_model
`default_nettype wire

// *** tb_cbe_card_ctrl.sv ***
// Self-checking bench for the card block, erase and protection controller
`timescale 1ns/1ps
`default_nettype none
module tb_cbe_card_ctrl import cbe_pkg::*; ;
  logic        ref_clk  = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        spi_mode = 1'b0;
  logic        grp32    = 1'b1;
  logic        req_valid, req_busy, rsp_valid;
  cbe_req_t    req;
  cbe_rsp_t    rsp, r;
  logic [15:0] cfg_low;
  logic [31:0] st;
  int          miscompares = 0, samples_checked = 0, cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  // Offset start keeps the two clocks out of phase
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  cbe_card_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b), .spi_mode(spi_mode),
    .grp32(grp32), .link_clk(link_clk), .req_valid(req_valid), .req(req),
    .req_busy(req_busy), .rsp_valid(rsp_valid), .rsp(rsp), .cfg_low(cfg_low));
  cbe_host_model u_host (.link_clk(link_clk), .req_busy(req_busy),
    .rsp_valid(rsp_valid), .rsp(rsp), .req_valid(req_valid), .req(req));
  // ==========================================================================
  // Tasks
  task automatic go(input cbe_cmd_t c, input logic [31:0] a);
    u_host.xfer(c, a, r);
  endtask : go
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic end_of_test();
    $display("TB: checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // Erase walk plus traffic stays well inside this ceiling
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    // Reset held long enough for the link-side synchroniser too
    repeat (4) @(posedge link_clk);
    @(negedge ref_clk) rst_b = 1'b1;
    repeat (4) @(posedge link_clk);
    chk("cfg reset", {16'h0000, CFG_RESET}, {16'h0000, cfg_low});
    $display("TB: reset test done");
    go(CMD_ERASE, 32'h0);
    chk_bit("erase order", 1'b1, r.status[ST_ER_SEQ]);
    @(negedge ref_clk) grp32 = 1'b0;
    go(CMD_TAG_START, 32'h0);
    go(CMD_TAG_END, 32'h2000);
    st = r.status;
    go(CMD_ERASE, 32'h0);
    st = st | r.status;
    chk_bit("erase span", 1'b1, st[ST_ER_PARAM]);
    @(negedge ref_clk) grp32 = 1'b1;
    go(CMD_TAG_START, 32'h0);
    go(CMD_TAG_END, 32'h2000);
    go(CMD_DESELECT_ERASE, 32'h2000);
    st = r.status;
    go(CMD_ERASE, 32'h0);
    st = st | r.status;
    chk("erase ok", 32'h0, st & 32'hFC20_0000);
    go(CMD_TAG_START, 32'h8000_0000);
    go(CMD_TAG_END, 32'h8000_4000);
    go(CMD_DESELECT_ERASE, 32'h0);
    chk_bit("mixed units", 1'b1, r.status[ST_ER_PARAM]);
    go(CMD_STOP, 32'h0);
    chk_bit("tag cancel", 1'b1, r.status[ST_ER_SEQ]);
    $display("TB: erase test done");
    @(negedge ref_clk) spi_mode = 1'b1;
    go(CMD_OP_COND, 32'h0);
    chk("spi op cond", 32'h4, r.status & 32'hFFFF_0004);
    go(CMD_IDENTIFY, 32'h0);
    chk("spi identify", 32'h4, r.status & 32'hFFFF_0004);
    go(CMD_SET_BLKLEN, 32'h4);
    go(CMD_READ_MULTI, 32'h1FC);
    for (int i = 0; i < 8; i++) begin
      go(CMD_DATA_OUT, 32'h0);
      chk("erased byte", {24'h0, ERASED_BYTE}, {24'h0, r.data});
    end
    go(CMD_STOP, 32'h0);
    chk("spi stop", 32'h0, r.status & 32'hFFFF_FE04);
    $display("TB: spi test done");
    @(negedge ref_clk) spi_mode = 1'b0;
    go(CMD_WRITE_SINGLE, 32'h401);
    chk_bit("misaligned write", 1'b1, r.status[ST_ALIGN]);
    go(CMD_WRITE_MULTI, 32'h400);
    for (int i = 0; i < 4; i++) begin
      go(CMD_DATA_IN, 32'h0000_00A5 + i);
      chk("write byte", 32'h0000_0100, r.status);
    end
    go(CMD_STOP, 32'h0);
    chk("write stop", 32'h0, r.status);
    $display("TB: write test done");
    go(CMD_READ_SINGLE, 32'h1FE);
    chk_bit("cross sector", 1'b1, r.status[ST_BLKLEN]);
    go(CMD_READ_CONFIG, 32'h0);
    for (int i = 0; i < 16; i++) begin
      go(CMD_DATA_OUT, 32'h0);
      if (i < 14)
        chk("maker byte", {24'h0, MAKER_DATA[111-8*i -: 8]}, {24'h0, r.data});
      else
        chk("cfg byte", {24'h0, CFG_RESET[127-8*i -: 8]}, {24'h0, r.data});
    end
    go(CMD_PROGRAM_CONFIG, 32'h6001);
    chk("cfg set", 32'h6001, {16'h0000, cfg_low});
    go(CMD_PROGRAM_CONFIG, 32'h2001);
    chk_bit("copy clear", 1'b1, r.status[ST_CFG_OVR]);
    chk("cfg kept", 32'h6001, {16'h0000, cfg_low});
    go(CMD_PROGRAM_CONFIG, 32'h5001);
    chk("perm kept", 32'h7001, {16'h0000, cfg_low});
    go(CMD_WRITE_SINGLE, 32'h0);
    chk_bit("write prot", 1'b1, r.status[ST_WP]);
    $display("TB: config test done");
    end_of_test();
  end
endmodule : tb_cbe_card_ctrl
`default_nettype wire
